// >>> include/ssf_pkg.sv
// Purpose: Shared constants and carriers for the serial status flag block
// Assumes: One 125 MHz clock, synchronous active-high reset
// Notes: Register offsets are word indices on the plain register port
package ssf_pkg;
   // -----------------------------
   // Register map
   // -----------------------------
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_RX_DATA = 4'h2;
   localparam logic [3:0] ADDR_TX_DATA = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
   // -----------------------------
   // Status bit positions
   // -----------------------------
   localparam int BIT_TX_EMPTY = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_OVERRUN = 5;
   localparam int BIT_FRAMING = 4;
   // -----------------------------
   // Control bit positions
   // -----------------------------
   localparam int BIT_TX_ENABLE = 0;
   localparam int BIT_RX_ENABLE = 1;
   localparam int BIT_TWO_STOP = 2;
   localparam int BIT_SYNC_MODE = 3;
   // -----------------------------
   // Interrupt bit positions
   // -----------------------------
   localparam int IRQ_RX_FULL = 0;
   localparam int IRQ_TX_EMPTY = 1;
   localparam int IRQ_ERROR = 2;
   // -----------------------------
   // Reset values
   // -----------------------------
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [2:0] RESET_IRQ_MASK = 3'h0;

   typedef struct packed {
      logic tx_empty;
      logic rx_full;
      logic overrun;
      logic framing;
   } ssf_flags_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssf_bus_s;

   typedef struct packed {
      logic done;
      logic stop1;
      logic stop2;
      logic [7:0] data;
   } ssf_rx_end_s;
endpackage

// >>> src/ssf_edge.sv
// Purpose: One sticky interrupt status bit with write-one-to-clear
// Assumes: Set and clear are single-cycle pulses on ref_clk
// Notes: Set has priority over a clear in the same cycle
`timescale 1ns/10ps
module ssf_edge (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Control
   input wire logic set_pulse,
   input wire logic clr_pulse,
   // Result
   output logic sticky
);
   typedef struct packed {
      logic bit_q;
   } ssf_edge_s;
   ssf_edge_s st, next_st;

   always_comb begin
      next_st = st;
      if (clr_pulse) begin
         next_st.bit_q = 1'b0;
      end
      if (set_pulse) begin
         next_st.bit_q = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sticky = st.bit_q;

   set_wins_a: assert property (@(posedge ref_clk) disable iff (srst) set_pulse |=> sticky)
      else $error("sticky bit missed a set");
endmodule

// >>> src/ssf_status.sv
// Purpose: Receive/transmit status flags, data buffers and register port
// Assumes: Shifters outside; receive end reported as a one-cycle pulse
// Notes: Flags clear by writing zero after reading them as one; controller reads clear rx_full; controller writes clear tx_empty if tx enabled and not loading
`timescale 1ns/10ps
module ssf_status #(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Receive shifter side
   input wire logic rx_done,
   input wire logic rx_stop1,
   input wire logic rx_stop2,
   input wire logic [DATA_W-1:0] receive_shifter,
   output logic rx_allowed,
   // Transmit shifter side
   input wire logic tx_load,
   output logic [DATA_W-1:0] transmit_buffer,
   output logic tx_allowed,
   // Transfer controller side
   input wire logic ctl_rx_read,
   input wire logic ctl_tx_write,
   input wire logic [DATA_W-1:0] ctl_tx_data,
   output logic [DATA_W-1:0] ctl_rx_data,
   // Interrupt requests
   output logic receive_full_irq,
   output logic transmit_empty_irq,
   output logic irq
);
   if (DATA_W != 8) begin : g_width_check
      $error("ssf_status supports an 8-bit character only");
   end

   typedef struct packed {
      ssf_pkg::ssf_flags_s flags;
      ssf_pkg::ssf_flags_s seen;
      logic [7:0] serial_control_reg;
      logic [DATA_W-1:0] receive_buffer;
      logic [DATA_W-1:0] tx_buf;
      logic [7:0] rdata;
      logic [2:0] irq_mask;
   } ssf_state_s;

   ssf_state_s st, next_st;
   ssf_pkg::ssf_bus_s bus;
   ssf_pkg::ssf_rx_end_s rx_end;
   logic rx_halt;
   logic stop_ok;
   logic rx_err_evt;
   logic irq_clr_wr;
   logic [2:0] irq_sticky;
   logic [2:0] irq_set;
   logic receive_enable_bit;
   logic transmit_enable_bit;
   logic two_stop;
   logic sync_mode;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign rx_end = '{done: rx_done, stop1: rx_stop1, stop2: rx_stop2, data: receive_shifter};
   assign receive_enable_bit = st.serial_control_reg[ssf_pkg::BIT_RX_ENABLE];
   assign transmit_enable_bit = st.serial_control_reg[ssf_pkg::BIT_TX_ENABLE];
   assign two_stop = st.serial_control_reg[ssf_pkg::BIT_TWO_STOP];
   assign sync_mode = st.serial_control_reg[ssf_pkg::BIT_SYNC_MODE];

   // -----------------------------
   // Receive gating
   // -----------------------------
   // Second stop bit deliberately unused even in two-stop mode
   assign stop_ok = rx_end.stop1 | (two_stop & 1'b0);
   assign rx_halt = st.flags.framing | st.flags.overrun;
   assign rx_allowed = receive_enable_bit & ~rx_halt;
   assign tx_allowed = transmit_enable_bit & ~(sync_mode & rx_halt);
   assign rx_err_evt = rx_end.done & receive_enable_bit & ~rx_halt & (~stop_ok | st.flags.rx_full);

   // -----------------------------
   // Flag and register update
   // -----------------------------
   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            ssf_pkg::ADDR_STATUS: begin
               next_st.rdata = {st.flags, 4'h0};
               next_st.seen = st.flags;
            end
            ssf_pkg::ADDR_CONTROL: next_st.rdata = st.serial_control_reg;
            ssf_pkg::ADDR_RX_DATA: next_st.rdata = st.receive_buffer;
            ssf_pkg::ADDR_TX_DATA: next_st.rdata = st.tx_buf;
            ssf_pkg::ADDR_IRQ_STATUS: next_st.rdata = {5'h00, irq_sticky};
            ssf_pkg::ADDR_IRQ_MASK: next_st.rdata = {5'h00, st.irq_mask};
            default: next_st.rdata = 8'h00;
         endcase
      end
      if (bus.wr) begin
         unique case (bus.addr)
            ssf_pkg::ADDR_STATUS: begin
               // Zero clears only a flag already read as one; ones ignored
               if (!bus.wdata[ssf_pkg::BIT_TX_EMPTY] && st.seen.tx_empty) next_st.flags.tx_empty = 1'b0;
               if (!bus.wdata[ssf_pkg::BIT_RX_FULL] && st.seen.rx_full) next_st.flags.rx_full = 1'b0;
               if (!bus.wdata[ssf_pkg::BIT_OVERRUN] && st.seen.overrun) next_st.flags.overrun = 1'b0;
               if (!bus.wdata[ssf_pkg::BIT_FRAMING] && st.seen.framing) next_st.flags.framing = 1'b0;
               next_st.seen = '0;
            end
            ssf_pkg::ADDR_CONTROL: next_st.serial_control_reg = {4'h0, bus.wdata[3:0]};
            ssf_pkg::ADDR_TX_DATA: next_st.tx_buf = bus.wdata;
            ssf_pkg::ADDR_IRQ_MASK: next_st.irq_mask = bus.wdata[2:0];
            default: ;
         endcase
      end
      if (ctl_tx_write) begin
         next_st.tx_buf = ctl_tx_data;
         next_st.flags.tx_empty = 1'b0;
      end
      if (ctl_rx_read) begin
         next_st.flags.rx_full = 1'b0;
      end
      if (!transmit_enable_bit || tx_load) begin
         next_st.flags.tx_empty = 1'b1;
      end
      // Disabled receiver touches nothing here
      if (rx_end.done && receive_enable_bit && !rx_halt) begin
         if (st.flags.rx_full) begin
            next_st.flags.overrun = 1'b1;
         end else if (!stop_ok) begin
            next_st.flags.framing = 1'b1;
            next_st.receive_buffer = rx_end.data;
         end else begin
            next_st.receive_buffer = rx_end.data;
            next_st.flags.rx_full = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= '0;
         st.flags.tx_empty <= 1'b1;
         st.serial_control_reg <= ssf_pkg::RESET_CONTROL;
         st.irq_mask <= ssf_pkg::RESET_IRQ_MASK;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------
   // Interrupts
   // -----------------------------
   assign irq_clr_wr = bus.wr && (bus.addr == ssf_pkg::ADDR_IRQ_STATUS);
   assign irq_set = {rx_err_evt, next_st.flags.tx_empty & ~st.flags.tx_empty,
                     next_st.flags.rx_full & ~st.flags.rx_full};

   for (genvar i = 0; i < 3; i++) begin : g_irq
      ssf_edge u_bit (
         .ref_clk(ref_clk),
         .srst(srst),
         .set_pulse(irq_set[i]),
         .clr_pulse(irq_clr_wr & bus.wdata[i]),
         .sticky(irq_sticky[i])
      );
   end

   assign irq = |(irq_sticky & st.irq_mask);
   assign receive_full_irq = st.flags.rx_full;
   assign transmit_empty_irq = st.flags.tx_empty & transmit_enable_bit;
   assign reg_rdata = st.rdata;
   assign transmit_buffer = st.tx_buf;
   assign ctl_rx_data = st.receive_buffer;

   // -----------------------------
   // Checks
   // -----------------------------
   sequence s_clean_end;
      rx_done && receive_enable_bit && !rx_halt && rx_stop1 && !st.flags.rx_full;
   endsequence
   sequence s_bad_stop;
      rx_done && receive_enable_bit && !rx_halt && !rx_stop1 && !st.flags.rx_full;
   endsequence

   framing_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      s_bad_stop |=> st.flags.framing) else $error("framing flag not set");
   second_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
      s_clean_end |=> !st.flags.framing) else $error("second stop bit was checked");
   framing_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
      s_bad_stop |=> (st.receive_buffer == $past(receive_shifter)) && !rx_allowed)
      else $error("framing error data or halt wrong");
   sync_block_a: assert property (@(posedge ref_clk) disable iff (srst)
      (sync_mode && rx_halt) |-> !tx_allowed) else $error("transmit not blocked");
   rx_off_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      (!receive_enable_bit && !bus.wr && !ctl_rx_read) |=> $stable(st.receive_buffer) && $stable(st.flags.rx_full))
      else $error("disabled receiver changed state");
   overrun_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
      (rx_done && receive_enable_bit && !rx_halt && st.flags.rx_full)
      |=> st.flags.overrun && $stable(st.receive_buffer)) else $error("overrun handling wrong");
   clean_load_a: assert property (@(posedge ref_clk) disable iff (srst)
      s_clean_end |=> st.flags.rx_full && (st.receive_buffer == $past(receive_shifter)))
      else $error("clean receive not loaded");
   one_ignored_a: assert property (@(posedge ref_clk) disable iff (srst)
      (bus.wr && bus.addr == ssf_pkg::ADDR_STATUS && bus.wdata[ssf_pkg::BIT_OVERRUN] && st.flags.overrun)
      |=> st.flags.overrun) else $error("write of one cleared overrun");
   tx_write_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      (ctl_tx_write && transmit_enable_bit && !tx_load) |=> !st.flags.tx_empty)
      else $error("empty flag not cleared on write");
   tx_empty_set_a: assert property (@(posedge ref_clk) disable iff (srst)
      (!transmit_enable_bit || tx_load) |=> st.flags.tx_empty) else $error("empty flag not set");
   rx_read_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
      (ctl_rx_read && !rx_done) |=> !st.flags.rx_full) else $error("full flag not cleared on read");
endmodule

// >>> bench/ssf_far_model.sv
// Purpose: Stand-in for the receive and transmit shifters of the serial line
// Assumes: Tasks are called from the bench; one character per call
// Notes: Data lines show the inverse of the last character between frames
`timescale 1ns/10ps
module ssf_far_model (
   // Clock
   input wire logic ref_clk,
   // Receive side
   output ssf_pkg::ssf_rx_end_s rx_end,
   // Transmit side
   input wire logic [7:0] transmit_buffer,
   output logic tx_load,
   output logic [7:0] tx_seen
);
   initial begin
      rx_end = '0;
      tx_load = 1'b0;
      tx_seen = 8'h00;
   end

   // One character ends; stop levels as given
   task automatic send(input logic [7:0] d, input logic s1, input logic s2);
      @(posedge ref_clk);
      rx_end <= '{done: 1'b1, stop1: s1, stop2: s2, data: d};
      @(posedge ref_clk);
      // Released line must not keep showing the character
      rx_end <= '{done: 1'b0, stop1: ~s1, stop2: ~s2, data: ~d};
      // Let the edge that takes the character settle before the bench looks
      #1;
   endtask

   // Shifter takes the buffered character
   task automatic pull();
      @(posedge ref_clk);
      tx_load <= 1'b1;
      tx_seen <= transmit_buffer;
      @(posedge ref_clk);
      tx_load <= 1'b0;
   endtask
endmodule

// >>> bench/ssf_status_tb.sv
// Purpose: Self-checking bench for the status flag block
// Assumes: Register port reads answer one cycle after the strobe
// Notes: Expected values are written out from the flag layout
`timescale 1ns/10ps
module ssf_status_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   ssf_pkg::ssf_bus_s bus = '0;
   ssf_pkg::ssf_rx_end_s rx_end;
   logic [7:0] reg_rdata, transmit_buffer, ctl_rx_data, tx_seen, rdv;
   logic [7:0] ctl_tx_data = 8'h00;
   logic ctl_rx_read = 1'b0;
   logic ctl_tx_write = 1'b0;
   logic tx_load, rx_allowed, tx_allowed, rfi, tei, irq;
   int err_total = 0;
   int checked = 0;

   always #4 ref_clk = ~ref_clk;

   ssf_status dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(bus.addr), .reg_wdata(bus.wdata),
      .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(reg_rdata), .rx_done(rx_end.done),
      .rx_stop1(rx_end.stop1), .rx_stop2(rx_end.stop2), .receive_shifter(rx_end.data),
      .rx_allowed(rx_allowed), .tx_load(tx_load), .transmit_buffer(transmit_buffer),
      .tx_allowed(tx_allowed), .ctl_rx_read(ctl_rx_read), .ctl_tx_write(ctl_tx_write),
      .ctl_tx_data(ctl_tx_data), .ctl_rx_data(ctl_rx_data), .receive_full_irq(rfi),
      .transmit_empty_irq(tei), .irq(irq));

   ssf_far_model far (.ref_clk(ref_clk), .rx_end(rx_end), .transmit_buffer(transmit_buffer),
      .tx_load(tx_load), .tx_seen(tx_seen));

   task automatic complete_run();
      $display("checked %0d, err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      #1;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic ctl(input logic rx_rd, input logic tx_wr, input logic [7:0] d);
      @(posedge ref_clk);
      ctl_rx_read <= rx_rd;
      ctl_tx_write <= tx_wr;
      ctl_tx_data <= d;
      @(posedge ref_clk);
      ctl_rx_read <= 1'b0;
      ctl_tx_write <= 1'b0;
      #1;
   endtask

   // Hang guard
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 8'h80);
      wr(4'h1, 8'h03);
      chk({7'h00, tei}, 8'h01);
      far.send(8'hA5, 1'b1, 1'b1);
      chk(ctl_rx_data, 8'hA5);
      chk({7'h00, rfi}, 8'h01);
      rd(4'h0, 8'hC0);
      far.send(8'h3C, 1'b1, 1'b1);
      chk(ctl_rx_data, 8'hA5);
      chk({7'h00, rx_allowed}, 8'h00);
      rd(4'h0, 8'hE0);
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'hE0);
      wr(4'h0, 8'hDF);
      // No status read between the two writes
      wr(4'h0, 8'h00);
      rd(4'h0, 8'hC0);
      ctl(1'b1, 1'b0, 8'h00);
      rd(4'h0, 8'h80);
      far.send(8'h3C, 1'b0, 1'b1);
      chk(ctl_rx_data, 8'h3C);
      rd(4'h0, 8'h90);
      far.send(8'h11, 1'b1, 1'b1);
      chk(ctl_rx_data, 8'h3C);
      wr(4'h1, 8'h01);
      rd(4'h0, 8'h90);
      chk(ctl_rx_data, 8'h3C);
      wr(4'h0, 8'hEF);
      far.send(8'h99, 1'b1, 1'b1);
      rd(4'h0, 8'h80);
      chk(ctl_rx_data, 8'h3C);
      wr(4'h1, 8'h07);
      far.send(8'h5A, 1'b1, 1'b0);
      rd(4'h0, 8'hC0);
      chk(ctl_rx_data, 8'h5A);
      ctl(1'b1, 1'b0, 8'h00);
      wr(4'h1, 8'h0F);
      chk({7'h00, tx_allowed}, 8'h01);
      far.send(8'h66, 1'b0, 1'b1);
      chk({7'h00, tx_allowed}, 8'h00);
      rd(4'h0, 8'h90);
      wr(4'h0, 8'hEF);
      chk({7'h00, tx_allowed}, 8'h01);
      ctl(1'b0, 1'b1, 8'h77);
      rd(4'h0, 8'h00);
      chk(transmit_buffer, 8'h77);
      far.pull();
      #1;
      chk(tx_seen, 8'h77);
      rd(4'h0, 8'h80);
      ctl(1'b0, 1'b1, 8'h12);
      rd(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      rd(4'h0, 8'h80);
      rd(4'h2, 8'h66);
      rd(4'h4, 8'h07);
      chk({7'h00, irq}, 8'h00);
      wr(4'h5, 8'h04);
      chk({7'h00, irq}, 8'h01);
      wr(4'h4, 8'h07);
      chk({7'h00, irq}, 8'h00);
      rd(4'h4, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      complete_run();
   end
endmodule
